// ==== core/rsa_params.svh ====
`ifndef RSA_PARAMS_SVH
`define RSA_PARAMS_SVH
// ****************************************
// Start-up timing
// ****************************************
`define MODE0_CYC 20'd8204
`define MODE1_CYC 20'd555386
`define MODE2_CYC 20'd73745
`define MODE3_CYC 20'd620927
`define MODE4_CYC 20'd53388
`define MODE5_CYC 20'd9
`define SAMPLE_CYC 20'd2
`define CLK_PERIOD_NS 8
`define ALERT_PULSE_NS 1000
`define ALERT_PULSE_CYC (`ALERT_PULSE_NS / `CLK_PERIOD_NS)
`define EE_HALF_CYC 4
`define AUTOLOAD_BYTES 256
// ****************************************
// Register addresses
// ****************************************
`define FAULT_PEND_ADDR 16'h8004
`define FAULT_PEND_ALT 16'h800A
`define RX_LOW_ADDR 16'h8006
`define RX_LOW_ALT 16'h800B
`define RX_HIGH_ADDR 16'h8008
`define RX_HIGH_ALT 16'h800C
`define LABEL_BASE 16'h8010
`define FAULT_EN_ADDR 16'h804A
`define SELFTEST_UPPER 16'h807A
`define AL_FAIL_LOW 16'h807B
`define AL_FAIL_HIGH 16'h807C
// ****************************************
// Fields and memory map
// ****************************************
`define BIT_MEMORY_CHECK_FAIL_FLAG 3
`define BIT_AUTOLOAD_CHECKSUM_ERROR 4
`define BIT_AUTOLOAD_COMPARE_ERROR 5
`define BIT_EEPROM_PROGRAM_MISMATCH 6
`define FAULT_FIXED_MASK 8'hF8
`define CFG_LO_WORD 13'h1000
`define CFG_HI_WORD 13'h1AFF
`define LAST_WORD 13'h1FFF
`define EE_READ_CMD 8'h03
`define EE_HDR_BYTES 16'h0003
`endif

// ==== core/rsa_pkg.sv ====
package rsa_pkg;
   typedef enum logic [3:0] {
      ST_SAMPLE, ST_TEST_W, ST_TEST_R, ST_TEST_CW, ST_TEST_CR, ST_CLEAR,
      ST_EE_CMD, ST_EE_DATA, ST_WAIT, ST_IDLE, ST_ACTIVE, ST_SAFE
   } seq_state_type;
endpackage

// ==== core/ee_shifter.sv ====
`timescale 1ns/1ps
`include "rsa_params.svh"
module ee_shifter #(
   parameter int HALF_CYC = `EE_HALF_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [7:0] tx_byte,
   input wire logic miso,
   output logic done,
   output logic [7:0] rx_byte,
   output logic sclk,
   output logic mosi
);
   logic busy_reg, busy_next, ph_reg, ph_next, done_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next, rx_next;
   logic [7:0] cnt_reg, cnt_next;
   logic sclk_next, mosi_next;

   always_comb begin
      busy_next = busy_reg;
      ph_next = ph_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      rx_next = rx_byte;
      cnt_next = cnt_reg;
      sclk_next = sclk;
      mosi_next = mosi;
      done_next = 1'b0;
      if (!busy_reg && start) begin
         busy_next = 1'b1;
         sh_next = tx_byte;
         bit_next = 3'h7;
         ph_next = 1'b0;
         cnt_next = 8'h00;
         mosi_next = tx_byte[7];
         sclk_next = 1'b0;
      end else if (busy_reg) begin
         cnt_next = cnt_reg + 8'h01;
         if (cnt_reg == 8'(HALF_CYC - 1)) begin
            cnt_next = 8'h00;
            ph_next = !ph_reg;
            sclk_next = !ph_reg;
            if (ph_reg) begin
               sh_next = {sh_reg[6:0], miso};
               mosi_next = sh_reg[6];
               bit_next = bit_reg - 3'h1;
               if (bit_reg == 3'h0) begin
                  busy_next = 1'b0;
                  done_next = 1'b1;
                  rx_next = {sh_reg[6:0], miso};
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_reg <= 1'b0;
         ph_reg <= 1'b0;
         bit_reg <= 3'h0;
         sh_reg <= 8'h00;
         rx_byte <= 8'h00;
         cnt_reg <= 8'h00;
         sclk <= 1'b0;
         mosi <= 1'b0;
         done <= 1'b0;
      end else begin
         busy_reg <= busy_next;
         ph_reg <= ph_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         rx_byte <= rx_next;
         cnt_reg <= cnt_next;
         sclk <= sclk_next;
         mosi <= mosi_next;
         done <= done_next;
      end
   end
endmodule

// ==== core/reset_startup_and_alert_control.sv ====
`timescale 1ns/1ps
`include "rsa_params.svh"
module reset_startup_and_alert_control
   import rsa_pkg::*;
#(
   parameter logic [19:0] MODE0_CYC = `MODE0_CYC,
   parameter logic [19:0] MODE1_CYC = `MODE1_CYC,
   parameter logic [19:0] MODE2_CYC = `MODE2_CYC,
   parameter logic [19:0] MODE3_CYC = `MODE3_CYC,
   parameter logic [19:0] MODE4_CYC = `MODE4_CYC,
   parameter int AUTOLOAD_BYTES = `AUTOLOAD_BYTES
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [2:0] STARTUP_SELECT_IN,
   output logic [2:0] STARTUP_SELECT_OUT,
   output logic [2:0] STARTUP_SELECT_OE,
   input wire logic EE_MISO,
   input wire logic RUN,
   input wire logic ACK_N,
   output logic INT_N,
   output logic READY,
   output logic ACTIVE,
   output logic SAFE_STATE,
   output logic CFG_DEFAULTS,
   output logic [12:0] MEM_ADDR,
   output logic [31:0] MEM_WDATA,
   output logic [3:0] MEM_BE,
   output logic MEM_WE,
   output logic MEM_RE,
   input wire logic [31:0] MEM_RDATA,
   input wire logic SWRST_VALID,
   input wire logic [2:0] SWRST_MODE,
   input wire logic RX_MSG_VALID,
   input wire logic [3:0] RX_MSG_CHAN,
   input wire logic [7:0] RX_MSG_LABEL,
   input wire logic RX_LABEL_ALERT,
   input wire logic [15:0] RX_ALERT_MASK,
   input wire logic [2:0] FLAG_EVENT,
   input wire logic [2:0] FLAG_ENABLE,
   input wire logic COPY_ERR_EVENT,
   input wire logic REG_RD,
   input wire logic [15:0] REG_ADDR,
   output logic [7:0] REG_RDATA
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] sel_s1, sel_s2;
   logic [3:0] pin_s1, pin_s2;
   logic run_d;
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
         pin_s1 <= 4'h2;
         pin_s2 <= 4'h2;
         run_d <= 1'b0;
      end else begin
         sel_s1 <= STARTUP_SELECT_IN;
         sel_s2 <= sel_s1;
         pin_s1 <= {EE_MISO, RUN, ACK_N, 1'b0};
         pin_s2 <= pin_s1;
         run_d <= pin_s2[2];
      end
   end
   logic miso_s, run_rise, ack_low;
   assign miso_s = pin_s2[3];
   assign run_rise = pin_s2[2] && !run_d;
   assign ack_low = !pin_s2[1];

   // ****************************************
   // Start-up sequencer
   // ****************************************
   seq_state_type st_reg, st_next;
   logic [2:0] mode_reg, mode_next, seq_reg, seq_next;
   logic [19:0] el_reg, el_next, target;
   logic [12:0] addr_next;
   logic [15:0] idx_reg, idx_next, fail_reg, fail_next;
   logic [7:0] sum_reg, sum_next, sh_tx, sh_rx;
   logic [31:0] wd_next;
   logic [3:0] be_next;
   logic we_next, re_next, vp_reg, vp_next, sh_start, sh_done, sh_sclk, sh_mosi;
   logic c1_v, c1_vn, c2_v, c2_ee, c1_ee, c1_een, cfg_next, cmp_fail;
   logic [31:0] c1_exp, c1_expn, c1_msk, c1_mskn, c2_exp, c2_msk;
   logic [15:0] c1_a, c1_an, c2_a;
   logic memory_check_fail_flag_ev, autoload_checksum_error_ev, autoload_compare_error_ev;
   logic [2:0] pins_next;

   ee_shifter u_shift (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .start(sh_start),
      .tx_byte(sh_tx),
      .miso(miso_s),
      .done(sh_done),
      .rx_byte(sh_rx),
      .sclk(sh_sclk),
      .mosi(sh_mosi)
   );

   function automatic seq_state_type first_step(input logic [2:0] m);
      case (m)
         3'd2, 3'd3: first_step = ST_TEST_W;
         3'd0, 3'd1, 3'd4: first_step = ST_CLEAR;
         default: first_step = ST_WAIT;
      endcase
   endfunction

   always_comb begin
      case (seq_reg)
         3'd0: target = MODE0_CYC;
         3'd1: target = MODE1_CYC;
         3'd2: target = MODE2_CYC;
         3'd3: target = MODE3_CYC;
         3'd4: target = MODE4_CYC;
         default: target = `MODE5_CYC;
      endcase
   end

   assign cmp_fail = c2_v && (((MEM_RDATA ^ c2_exp) & c2_msk) != 32'h0);

   always_comb begin
      st_next = st_reg;
      mode_next = mode_reg;
      seq_next = seq_reg;
      el_next = (el_reg == 20'hFFFFF) ? el_reg : el_reg + 20'h1;
      addr_next = MEM_ADDR;
      idx_next = idx_reg;
      sum_next = sum_reg;
      fail_next = fail_reg;
      wd_next = 32'h0;
      be_next = 4'hF;
      we_next = 1'b0;
      re_next = 1'b0;
      vp_next = 1'b0;
      c1_vn = 1'b0;
      c1_een = 1'b0;
      c1_expn = 32'h0;
      c1_mskn = 32'hFFFFFFFF;
      c1_an = 16'h0;
      sh_start = 1'b0;
      sh_tx = 8'h00;
      cfg_next = 1'b0;
      memory_check_fail_flag_ev = 1'b0;
      autoload_checksum_error_ev = 1'b0;
      autoload_compare_error_ev = 1'b0;
      case (st_reg)
         ST_SAMPLE: begin
            if (el_reg == `SAMPLE_CYC) begin
               mode_next = sel_s2;
               seq_next = sel_s2;
               st_next = first_step(sel_s2);
               addr_next = 13'h0;
               cfg_next = (sel_s2 <= 3'd3);
            end
         end
         ST_TEST_W, ST_TEST_CW: begin
            we_next = 1'b1;
            wd_next = (st_reg == ST_TEST_W) ? 32'(MEM_ADDR) : ~32'(MEM_ADDR);
            addr_next = MEM_ADDR + 13'h1;
            if (MEM_ADDR == `LAST_WORD) begin
               st_next = (st_reg == ST_TEST_W) ? ST_TEST_R : ST_TEST_CR;
            end
         end
         ST_TEST_R, ST_TEST_CR: begin
            re_next = 1'b1;
            c1_vn = 1'b1;
            c1_expn = (st_reg == ST_TEST_R) ? 32'(MEM_ADDR) : ~32'(MEM_ADDR);
            addr_next = MEM_ADDR + 13'h1;
            if (MEM_ADDR == `LAST_WORD) begin
               st_next = (st_reg == ST_TEST_R) ? ST_TEST_CW : ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            // Mode 4 keeps the tables, so that range is walked but left alone.
            // The strobe is registered with the next address, so that address is tested.
            addr_next = MEM_ADDR + 13'h1;
            we_next = !(seq_reg == 3'd4 && addr_next >= `CFG_LO_WORD
                        && addr_next <= `CFG_HI_WORD);
            if (MEM_ADDR == `LAST_WORD) begin
               if (seq_reg == 3'd2) begin
                  st_next = ST_WAIT;
               end else begin
                  st_next = (seq_reg == 3'd0) ? ST_WAIT : ST_EE_CMD;
                  sh_start = (seq_reg != 3'd0);
                  sh_tx = `EE_READ_CMD;
                  idx_next = 16'h1;
                  sum_next = 8'h00;
               end
            end
         end
         ST_EE_CMD: begin
            if (sh_done) begin
               sh_start = 1'b1;
               idx_next = idx_reg + 16'h1;
               if (idx_reg == `EE_HDR_BYTES) begin
                  st_next = ST_EE_DATA;
                  idx_next = 16'h0;
               end
            end
         end
         ST_EE_DATA: begin
            if (vp_reg) begin
               re_next = 1'b1;
               c1_vn = 1'b1;
               c1_een = 1'b1;
               c1_expn = {4{sh_rx}};
               c1_mskn = 32'hFF << {idx_reg[1:0] - 2'h1, 3'h0};
               c1_an = idx_reg - 16'h1;
            end
            if (sh_done) begin
               sum_next = sum_reg + sh_rx;
               if (idx_reg == 16'(AUTOLOAD_BYTES)) begin
                  if (sum_reg + sh_rx != 8'h00) begin
                     autoload_checksum_error_ev = 1'b1;
                     st_next = ST_SAFE;
                  end else begin
                     st_next = ST_WAIT;
                  end
               end else begin
                  we_next = 1'b1;
                  vp_next = 1'b1;
                  addr_next = idx_reg[14:2];
                  be_next = 4'h1 << idx_reg[1:0];
                  wd_next = {4{sh_rx}};
                  idx_next = idx_reg + 16'h1;
                  sh_start = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (el_reg >= target - 20'h1) begin
               st_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (run_rise) begin
               st_next = ST_ACTIVE;
            end
         end
         default: begin
         end
      endcase
      if (cmp_fail) begin
         st_next = ST_SAFE;
         memory_check_fail_flag_ev = !c2_ee;
         autoload_compare_error_ev = c2_ee;
         if (c2_ee) begin
            fail_next = c2_a;
         end
      end
      if (SWRST_VALID && st_reg != ST_SAMPLE && st_reg != ST_SAFE) begin
         seq_next = SWRST_MODE;
         st_next = first_step(SWRST_MODE);
         el_next = 20'h0;
         addr_next = 13'h0;
         cfg_next = (SWRST_MODE <= 3'd3);
      end
      pins_next = {sh_sclk, sh_mosi, !(st_next == ST_EE_CMD || st_next == ST_EE_DATA)};
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= ST_SAMPLE;
         mode_reg <= 3'h0;
         seq_reg <= 3'h0;
         el_reg <= 20'h0;
         MEM_ADDR <= 13'h0;
         MEM_WDATA <= 32'h0;
         MEM_BE <= 4'h0;
         MEM_WE <= 1'b0;
         MEM_RE <= 1'b0;
         idx_reg <= 16'h0;
         sum_reg <= 8'h00;
         fail_reg <= 16'h0;
         vp_reg <= 1'b0;
         {c1_v, c2_v, c1_ee, c2_ee} <= 4'h0;
         {c1_exp, c2_exp, c1_msk, c2_msk} <= 128'h0;
         {c1_a, c2_a} <= 32'h0;
         CFG_DEFAULTS <= 1'b0;
         STARTUP_SELECT_OUT <= 3'h1;
      end else begin
         st_reg <= st_next;
         mode_reg <= mode_next;
         seq_reg <= seq_next;
         el_reg <= el_next;
         MEM_ADDR <= addr_next;
         MEM_WDATA <= wd_next;
         MEM_BE <= be_next;
         MEM_WE <= we_next;
         MEM_RE <= re_next;
         idx_reg <= idx_next;
         sum_reg <= sum_next;
         fail_reg <= fail_next;
         vp_reg <= vp_next;
         {c1_v, c1_ee, c1_exp, c1_msk, c1_a} <= {c1_vn, c1_een, c1_expn, c1_mskn, c1_an};
         {c2_v, c2_ee, c2_exp, c2_msk, c2_a} <= {c1_v, c1_ee, c1_exp, c1_msk, c1_a};
         CFG_DEFAULTS <= cfg_next;
         STARTUP_SELECT_OUT <= pins_next;
      end
   end

   // The select pins stay released until the sample is taken.
   assign STARTUP_SELECT_OE = (st_reg == ST_SAMPLE) ? 3'h0 : 3'h7;
   assign READY = (st_reg == ST_IDLE) || (st_reg == ST_ACTIVE);
   assign ACTIVE = (st_reg == ST_ACTIVE);
   assign SAFE_STATE = (st_reg == ST_SAFE);

   // ****************************************
   // Pending registers and alert pin
   // ****************************************
   logic [7:0] fp_reg, fp_next, fset, rd_next;
   logic [15:0] rp_reg, rp_next, rset;
   logic [7:0] lab_reg [16];
   logic [7:0] lab_next [16];
   logic rd_f, rd_l, rd_h, new_alert, il_reg, il_next, pm_reg, pm_next;
   logic [7:0] pc_reg, pc_next;

   always_comb begin
      fset = {1'b0, COPY_ERR_EVENT, autoload_compare_error_ev, autoload_checksum_error_ev, memory_check_fail_flag_ev, FLAG_EVENT};
      rset = (ACTIVE && RX_MSG_VALID && RX_LABEL_ALERT) ? 16'h1 << RX_MSG_CHAN : 16'h0;
      rd_f = REG_RD && (REG_ADDR == `FAULT_PEND_ADDR || REG_ADDR == `FAULT_PEND_ALT);
      rd_l = REG_RD && (REG_ADDR == `RX_LOW_ADDR || REG_ADDR == `RX_LOW_ALT);
      rd_h = REG_RD && (REG_ADDR == `RX_HIGH_ADDR || REG_ADDR == `RX_HIGH_ALT);
      // A set in the cycle of the clearing read survives the read.
      fp_next = (rd_f ? 8'h00 : fp_reg) | fset;
      rp_next = (rp_reg & ~{{8{rd_h}}, {8{rd_l}}}) | rset;
      lab_next = lab_reg;
      if (rset != 16'h0) begin
         lab_next[RX_MSG_CHAN] = RX_MSG_LABEL;
      end
      new_alert = ((fset & (`FAULT_FIXED_MASK | {5'h0, FLAG_ENABLE})) != 8'h0)
                  || ((rset & RX_ALERT_MASK) != 16'h0);
      il_next = il_reg;
      pm_next = pm_reg;
      pc_next = (pc_reg == 8'h00) ? 8'h00 : pc_reg - 8'h01;
      if (new_alert) begin
         il_next = 1'b1;
         pm_next = ack_low;
         pc_next = 8'(`ALERT_PULSE_CYC - 1);
      end else if (il_reg && (pm_reg ? pc_reg == 8'h00 : ack_low)) begin
         il_next = 1'b0;
      end
      rd_next = 8'h00;
      if (rd_f) rd_next = fp_reg;
      if (rd_l) rd_next = rp_reg[7:0];
      if (rd_h) rd_next = rp_reg[15:8];
      if (REG_ADDR[15:4] == `LABEL_BASE >> 4) rd_next = lab_reg[REG_ADDR[3:0]];
      if (REG_ADDR == `FAULT_EN_ADDR) rd_next = `FAULT_FIXED_MASK | {5'h0, FLAG_ENABLE};
      if (REG_ADDR == `SELFTEST_UPPER) rd_next = {mode_reg, 5'h00};
      if (REG_ADDR == `AL_FAIL_LOW) rd_next = fail_reg[7:0];
      if (REG_ADDR == `AL_FAIL_HIGH) rd_next = fail_reg[15:8];
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         fp_reg <= 8'h00;
         rp_reg <= 16'h0;
         lab_reg <= '{default: 8'h00};
         il_reg <= 1'b0;
         pm_reg <= 1'b0;
         pc_reg <= 8'h00;
         REG_RDATA <= 8'h00;
      end else begin
         fp_reg <= fp_next;
         rp_reg <= rp_next;
         lab_reg <= lab_next;
         il_reg <= il_next;
         pm_reg <= pm_next;
         pc_reg <= pc_next;
         REG_RDATA <= REG_RD ? rd_next : REG_RDATA;
      end
   end
   assign INT_N = !il_reg;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_alert_low8;
      (!INT_N)[*8];
   endsequence
   a_pins_released: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg == ST_SAMPLE |-> !READY && STARTUP_SELECT_OE == 3'h0 && STARTUP_SELECT_OUT == 3'h1)
      else $error("Ready or select pins active before sampling.");
   a_mode_held: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg != ST_SAMPLE |=> $stable(mode_reg))
      else $error("Sampled mode changed after sampling.");
   a_pins_driven: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg != ST_SAMPLE |-> STARTUP_SELECT_OE == 3'h7)
      else $error("Select pins not driven after sampling.");
   a_ready_time: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(READY) |-> el_reg >= target)
      else $error("Ready rose before the start-up count.");
   a_idle_quiet: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !ACTIVE && !REG_RD |=> $stable(rp_reg))
      else $error("Receive alert taken outside active state.");
   a_run_active: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg == ST_IDLE && run_rise && !SWRST_VALID |=> ACTIVE)
      else $error("Run edge did not enter active state.");
   a_mode_read: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      REG_RD && REG_ADDR == `SELFTEST_UPPER |=> REG_RDATA[7:5] == $past(mode_reg))
      else $error("Mode readback wrong.");
   a_safe_lock: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      st_reg == ST_SAFE |=> st_reg == ST_SAFE && !READY)
      else $error("Safe state left without master reset.");
   a_fault_alert: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      fset[`BIT_MEMORY_CHECK_FAIL_FLAG] || fset[`BIT_AUTOLOAD_CHECKSUM_ERROR]
      |=> !INT_N && fp_reg[`BIT_AUTOLOAD_CHECKSUM_ERROR:`BIT_MEMORY_CHECK_FAIL_FLAG] != 2'h0)
      else $error("Fault did not alert.");
   a_level_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !INT_N && !pm_reg && !ack_low |=> !INT_N)
      else $error("Alert released without acknowledge.");
   a_pulse_len: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      new_alert && ack_low |=> s_alert_low8)
      else $error("Alert pulse too short.");
   a_rx_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      rd_l && rset[7:0] == 8'h00 |=> rp_reg[7:0] == 8'h00)
      else $error("Receive low pending not cleared by read.");
endmodule

// ==== verif/mem_model.sv ====
`timescale 1ns/1ps
// ****
// Synchronous RAM behind the start-up engine.
// ****
module mem_model (
   input wire logic clk,
   input wire logic [12:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] be,
   input wire logic we,
   input wire logic re,
   output logic [31:0] rdata
);
   logic [31:0] mem [0:8191];
   // Idle read data toggles so that a stale word is never mistaken for an answer.
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (we && be[i]) begin
            mem[addr][8*i +: 8] <= wdata[8*i +: 8];
         end
      end
      rdata <= re ? mem[addr] : ~rdata;
   end
endmodule

// ==== verif/reset_startup_and_alert_control_tb.sv ====
`timescale 1ns/1ps
module reset_startup_and_alert_control_tb import rsa_pkg::*;;
   logic CORE_CLK = 0, RST_N = 0, RUN = 0, ACK_N = 1, REG_RD = 0, RX_MSG_VALID = 0;
   logic RX_LABEL_ALERT = 0, COPY_ERR_EVENT = 0, SWRST_VALID = 0, EE_MISO = 1;
   logic [2:0] SWRST_MODE = 0, FLAG_EVENT = 0, FLAG_ENABLE = 0, pins = 0;
   logic [2:0] STARTUP_SELECT_OUT, STARTUP_SELECT_OE;
   logic [15:0] REG_ADDR = 0, RX_ALERT_MASK = 0;
   logic [3:0] RX_MSG_CHAN = 0, MEM_BE;
   logic [7:0] RX_MSG_LABEL = 0, REG_RDATA;
   logic [12:0] MEM_ADDR;
   logic [31:0] MEM_WDATA, MEM_RDATA, old;
   logic MEM_WE, MEM_RE, INT_N, READY, ACTIVE, SAFE_STATE, CFG_DEFAULTS;
   wire [2:0] STARTUP_SELECT_IN = (STARTUP_SELECT_OE & STARTUP_SELECT_OUT) |
      (~STARTUP_SELECT_OE & pins);
   int fail_count = 0, n_checks = 0, n, a, n_cfg;
   int mt[3] = '{5, 0, 2};
   int ct[3] = '{9, 8204, 73745};
   reset_startup_and_alert_control #(
      .AUTOLOAD_BYTES(4)
   ) uut (.CORE_CLK, .RST_N, .STARTUP_SELECT_IN,
      .STARTUP_SELECT_OUT, .STARTUP_SELECT_OE, .EE_MISO, .RUN, .ACK_N, .INT_N, .READY,
      .ACTIVE, .SAFE_STATE, .CFG_DEFAULTS, .MEM_ADDR, .MEM_WDATA, .MEM_BE, .MEM_WE,
      .MEM_RE, .MEM_RDATA, .SWRST_VALID, .SWRST_MODE, .RX_MSG_VALID, .RX_MSG_CHAN,
      .RX_MSG_LABEL, .RX_LABEL_ALERT, .RX_ALERT_MASK, .FLAG_EVENT, .FLAG_ENABLE,
      .COPY_ERR_EVENT, .REG_RD, .REG_ADDR, .REG_RDATA);
   mem_model mem_i (.clk(CORE_CLK), .addr(MEM_ADDR), .wdata(MEM_WDATA), .be(MEM_BE),
      .we(MEM_WE), .re(MEM_RE), .rdata(MEM_RDATA));
   // ****
   // Tasks.
   // ****
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_reg(input logic [15:0] ad, input logic [7:0] e);
      @(negedge CORE_CLK);
      REG_RD = 1;
      REG_ADDR = ad;
      @(negedge CORE_CLK);
      REG_RD = 0;
      @(negedge CORE_CLK);
      cmp(REG_RDATA, e);
   endtask
   task automatic wait_int(input logic v);
      for (n = 0; n < 300 && INT_N !== v; n++) @(negedge CORE_CLK);
   endtask
   task automatic boot(input logic [2:0] m, input int e);
      @(negedge CORE_CLK);
      RST_N = 0;
      pins = m;
      #1 cmp(READY, 0);
      a = $urandom_range(8191);
      old = $urandom | 1;
      mem_i.mem[a] = old;
      repeat (29) @(negedge CORE_CLK);
      RST_N = 1;
      n_cfg = 0;
      for (n = 0; n < 80000 && READY !== 1'b1; n++) begin
         @(posedge CORE_CLK);
         #1;
         if (CFG_DEFAULTS === 1'b1) n_cfg++;
      end
      cmp(n >= e - 1 && n <= e + 1, 1);
      cmp(STARTUP_SELECT_OE, 3'h7);
      cmp({ACTIVE, SAFE_STATE}, 0);
      cmp(mem_i.mem[a], m == 5 ? old : 0);
      cmp(n_cfg, m <= 3);
      chk_reg(16'h807A, {m, 5'h00});
   endtask
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****
   // Stimulus.
   // ****
   initial forever #4 CORE_CLK = ~CORE_CLK;
   initial begin
      #(100000 * 8);
      fail_count++;
      give_verdict;
   end
   initial begin
      void'($urandom(40280));
      repeat (3) @(negedge CORE_CLK);
      for (int i = 0; i < 3; i++) boot(mt[i], ct[i]);
      RX_ALERT_MASK = 16'hFFFF;
      RX_MSG_VALID = 1;
      RX_LABEL_ALERT = 1;
      @(negedge CORE_CLK);
      RX_MSG_VALID = 0;
      cmp(INT_N, 1);
      RUN = 1;
      repeat (4) @(negedge CORE_CLK);
      cmp(ACTIVE, 1);
      for (int k = 0; k < 2; k++) begin
         RX_MSG_CHAN = $urandom;
         RX_MSG_LABEL = $urandom;
         RX_ALERT_MASK = $urandom | (16'h0001 << RX_MSG_CHAN);
         RX_MSG_VALID = 1;
         RX_LABEL_ALERT = 1;
         @(negedge CORE_CLK);
         RX_MSG_VALID = 0;
         wait_int(0);
         cmp(INT_N, 0);
         if (k == 0) begin
            repeat (20) @(negedge CORE_CLK);
            cmp(INT_N, 0);
            ACK_N = 0;
         end
         wait_int(1);
         cmp(k == 0 ? n < 8 : n >= 122 && n <= 128, 1);
         a = RX_MSG_CHAN[3] ? 16'h8008 : 16'h8006;
         chk_reg(a, 8'h01 << RX_MSG_CHAN[2:0]);
         chk_reg(a, 8'h00);
         chk_reg(16'h8010 + RX_MSG_CHAN, RX_MSG_LABEL);
      end
      FLAG_ENABLE = $urandom;
      FLAG_EVENT = 3'h1;
      COPY_ERR_EVENT = 1;
      @(negedge CORE_CLK);
      FLAG_EVENT = 0;
      COPY_ERR_EVENT = 0;
      wait_int(0);
      cmp(INT_N, 0);
      chk_reg(16'h8004, 8'h41);
      chk_reg(16'h800A, 8'h00);
      chk_reg(16'h804A, 8'hF8 | FLAG_ENABLE);
      chk_reg(16'h8100, 8'h00);
      SWRST_MODE = 3'h5;
      SWRST_VALID = 1;
      @(negedge CORE_CLK);
      SWRST_VALID = 0;
      cmp({READY, ACTIVE}, 0);
      for (n = 0; n < 100 && READY !== 1'b1; n++) @(negedge CORE_CLK);
      cmp(n >= ct[0] - 1 && n <= ct[0] + 1, 1);
      // An all-ones EEPROM image cannot sum to zero, so auto-load must lock up.
      @(negedge CORE_CLK);
      RST_N = 0;
      pins = 3'h4;
      repeat (29) @(negedge CORE_CLK);
      RST_N = 1;
      a = 0;
      for (n = 0; n < 20000 && SAFE_STATE !== 1'b1; n++) begin
         @(negedge CORE_CLK);
         if (STARTUP_SELECT_OUT[0] === 1'b0) a++;
      end
      cmp(a >= 512 && a <= 600, 1);
      cmp({SAFE_STATE, READY, INT_N}, 3'b100);
      RUN = 0;
      repeat (4) @(negedge CORE_CLK);
      RUN = 1;
      SWRST_VALID = 1;
      @(negedge CORE_CLK);
      SWRST_VALID = 0;
      repeat (12) @(negedge CORE_CLK);
      cmp({SAFE_STATE, READY, ACTIVE}, 3'b100);
      chk_reg(16'h8004, 8'h10);
      chk_reg(16'h807A, 8'h80);
      RST_N = 0;
      #1 cmp({READY, ACTIVE}, 0);
      give_verdict;
   end
endmodule
